/* File: hdl/eag_top.sv */
// Accumulation mode and channel gain configuration with APB slave
//
// Local design decision: register access over APB.
`timescale 1ns/10ps

// How it works
// [R01] Bit 7 reports tamper current input used
// [R02] Bit 6 picks fault entry or exit
// [R03] Bit 5 picks reactive sign change direction
// [R04] Bit 4 picks active sign change direction
// [R05] Bit 3 accumulates absolute reactive power
// [R06] Bit 2 flips reactive sign when active negative
// [R07] Bit 1 accumulates only positive active power
// [R08] Bit 0 accumulates absolute active power
// [R09] Gain bits 7:5 set voltage amp gain
// [R10] Gain bits 2:0 set current amp gain
// [R11] Gain bit 3 picks sign detect location
// [R12] Active sign change sets its status flag
// [R13] Fault change sets fault status flag
// [R14] Software writes only gain codes 0 to 4
module eag_top
(
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic [11:0]                paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Metering core inputs
    input  wire logic                       power_valid,
    input  wire logic [eag_pkg::PWR_W-1:0]  active_power,
    input  wire logic [eag_pkg::PWR_W-1:0]  reactive_power,
    input  wire logic                       active_pulse,
    input  wire logic                       active_pulse_negative,
    input  wire logic                       reactive_pulse,
    input  wire logic                       reactive_pulse_negative,
    input  wire logic                       fault_mode,
    input  wire logic                       tamper_current_input_indicator,
    // Accumulator feed
    output logic                            active_accum_valid,
    output logic      [eag_pkg::PWR_W-1:0]  active_accum_value,
    output logic                            reactive_accum_valid,
    output logic      [eag_pkg::PWR_W-1:0]  reactive_accum_value,
    // Front end and pulse configuration
    output logic [eag_pkg::GAIN_FLD_W-1:0]  voltage_amp_gain,
    output logic [eag_pkg::GAIN_FLD_W-1:0]  current_amp_gain,
    output logic                            pulse_sign_detect_location,
    // Interrupt
    output logic                            irq
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed
    {
        logic [7:0]                  acc;       // Accumulation mode control
        logic [7:0]                  gain;      // Channel gain control
        logic [eag_pkg::IRQ_W-1:0]   status;    // Sticky interrupt flags
        logic [eag_pkg::IRQ_W-1:0]   mask;      // Interrupt enables
        logic [31:0]                 rdata;     // Read data captured in setup
        logic                        err;       // Unmapped address flag
        logic                        act_vld;   // Active feed strobe
        logic [eag_pkg::PWR_W-1:0]   act_val;   // Active feed value
        logic                        rea_vld;   // Reactive feed strobe
        logic [eag_pkg::PWR_W-1:0]   rea_val;   // Reactive feed value
    } eag_state_s;

    localparam logic [eag_pkg::PWR_W-1:0] PWR_MAX = {1'b0, {(eag_pkg::PWR_W-1){1'b1}}};
    localparam logic [eag_pkg::PWR_W-1:0] PWR_MIN = {1'b1, {(eag_pkg::PWR_W-1){1'b0}}};

    eag_state_s                r;           // Registered state
    eag_state_s                n;           // Next state
    logic                      setup_ph;    // APB setup cycle
    logic                      access_ph;   // APB access cycle
    logic [eag_pkg::IRQ_W-1:0] evt;         // Event pulses this cycle
    logic                      act_smp_vld; // Active sign sample strobe
    logic                      act_smp_neg; // Active sign sample level
    logic                      rea_smp_vld; // Reactive sign sample strobe
    logic                      rea_smp_neg; // Reactive sign sample level

    // Negate with saturation so the most negative code cannot wrap
    function automatic logic [eag_pkg::PWR_W-1:0] sat_neg
    (
        input logic [eag_pkg::PWR_W-1:0] x
    );
        sat_neg = (x == PWR_MIN) ? PWR_MAX : (~x + 1'b1);
    endfunction

    // Magnitude with saturation
    function automatic logic [eag_pkg::PWR_W-1:0] sat_abs
    (
        input logic [eag_pkg::PWR_W-1:0] x
    );
        sat_abs = x[eag_pkg::PWR_W-1] ? sat_neg(x) : x;
    endfunction

    // ==========================================================
    // APB phase decode
    // ==========================================================
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign pready    = 1'b1;

    // ==========================================================
    // Sign and fault event detection
    // ==========================================================
    // Filtered power samples or per-pulse sign as detection source
    always_comb
    begin
        if (r.gain[eag_pkg::GAIN_LOC_BIT])
        begin
            act_smp_vld = active_pulse;                            // R11
            act_smp_neg = active_pulse_negative;
            rea_smp_vld = reactive_pulse;
            rea_smp_neg = reactive_pulse_negative;
        end
        else
        begin
            act_smp_vld = power_valid;                             // R11
            act_smp_neg = active_power[eag_pkg::PWR_W-1];
            rea_smp_vld = power_valid;
            rea_smp_neg = reactive_power[eag_pkg::PWR_W-1];
        end
    end

    // Active power sign change
    eag_sign_event u_act_evt
    (
        .pclk          (pclk),
        .presetn       (presetn),
        .sample_valid  (act_smp_vld),
        .sample_level  (act_smp_neg),
        .rising_select (r.acc[eag_pkg::ACC_ACT_SEL_BIT]),           // R04
        .change_event  (evt[eag_pkg::IRQ_ACT_BIT])
    );

    // Reactive power sign change
    eag_sign_event u_rea_evt
    (
        .pclk          (pclk),
        .presetn       (presetn),
        .sample_valid  (rea_smp_vld),
        .sample_level  (rea_smp_neg),
        .rising_select (r.acc[eag_pkg::ACC_REA_SEL_BIT]),           // R03
        .change_event  (evt[eag_pkg::IRQ_REA_BIT])
    );

    // Fault mode entry or exit, sampled every cycle
    eag_sign_event u_flt_evt
    (
        .pclk          (pclk),
        .presetn       (presetn),
        .sample_valid  (1'b1),
        .sample_level  (fault_mode),
        .rising_select (r.acc[eag_pkg::ACC_FAULT_BIT]),             // R02
        .change_event  (evt[eag_pkg::IRQ_FAULT_BIT])
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        n         = r;
        n.act_vld = power_valid;
        n.rea_vld = power_valid;
        // Capture read data and decode error in the setup cycle
        if (setup_ph)
        begin
            n.rdata = 32'h0000_0000;
            n.err   = 1'b0;
            case (paddr)
                eag_pkg::ADDR_ACC:
                begin
                    n.rdata[7:0] = {tamper_current_input_indicator,     // R01
                                    r.acc[6:0]};
                end
                eag_pkg::ADDR_GAIN: n.rdata[7:0] = r.gain;
                eag_pkg::ADDR_STAT: n.rdata[eag_pkg::IRQ_W-1:0] = r.status;
                eag_pkg::ADDR_MASK: n.rdata[eag_pkg::IRQ_W-1:0] = r.mask;
                default:            n.err = 1'b1;
            endcase
        end
        // Writes take effect at the end of the access cycle
        if (access_ph && pwrite)
        begin
            case (paddr)
                eag_pkg::ADDR_ACC:  n.acc  = pwdata[7:0] & eag_pkg::ACC_WMASK;
                eag_pkg::ADDR_GAIN: n.gain = pwdata[7:0] & eag_pkg::GAIN_WMASK; // R09 R10 R11
                eag_pkg::ADDR_MASK: n.mask = pwdata[eag_pkg::IRQ_W-1:0];
                default:            n.acc  = r.acc;
            endcase
        end
        // Write one to clear; a same-cycle event wins over the clear
        if (access_ph && pwrite && (paddr == eag_pkg::ADDR_STAT))
        begin
            n.status = r.status & ~pwdata[eag_pkg::IRQ_W-1:0];
        end
        n.status = n.status | evt;                                 // R12 R13
        // Active power shaping
        if (power_valid)
        begin
            if (r.acc[eag_pkg::ACC_ACT_ABS_BIT])
            begin
                n.act_val = sat_abs(active_power);                 // R08
            end
            else if (r.acc[eag_pkg::ACC_ACT_POS_BIT] && active_power[eag_pkg::PWR_W-1])
            begin
                n.act_val = '0;                                    // R07
            end
            else
            begin
                n.act_val = active_power;
            end
            // Reactive power shaping
            if (r.acc[eag_pkg::ACC_REA_ABS_BIT])
            begin
                n.rea_val = sat_abs(reactive_power);               // R05
            end
            else if (r.acc[eag_pkg::ACC_REA_SBA_BIT] && active_power[eag_pkg::PWR_W-1])
            begin
                n.rea_val = sat_neg(reactive_power);               // R06
            end
            else
            begin
                n.rea_val = reactive_power;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r        <= '0;
            r.acc    <= eag_pkg::ACC_RESET;
            r.gain   <= eag_pkg::GAIN_RESET;
            r.status <= eag_pkg::IRQ_RESET;
            r.mask   <= eag_pkg::IRQ_RESET;
        end
        else
        begin
            r <= n;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign prdata                     = r.rdata;
    assign pslverr                    = r.err;
    assign active_accum_valid         = r.act_vld;
    assign active_accum_value         = r.act_val;
    assign reactive_accum_valid       = r.rea_vld;
    assign reactive_accum_value       = r.rea_val;
    assign voltage_amp_gain           = r.gain[eag_pkg::GAIN_VOLT_LSB +: eag_pkg::GAIN_FLD_W];
    assign current_amp_gain           = r.gain[eag_pkg::GAIN_CUR_LSB +: eag_pkg::GAIN_FLD_W];
    assign pulse_sign_detect_location = r.gain[eag_pkg::GAIN_LOC_BIT];
    assign irq                        = |(r.status & r.mask);

    // ==========================================================
    // Assertions
    // ==========================================================
    AST_TAMPER_READ: assert property (@(posedge pclk) disable iff (!presetn) // R01
        (access_ph && !pwrite && paddr == eag_pkg::ADDR_ACC && $past(setup_ph))
        |-> prdata[7] == $past(tamper_current_input_indicator))
        else $error("Tamper indicator read mismatch");

    AST_FAULT_DIR: assert property (@(posedge pclk) disable iff (!presetn) // R02
        evt[eag_pkg::IRQ_FAULT_BIT] |-> ($past(fault_mode) != $past(fault_mode, 2))
        && ($past(fault_mode) == !$past(r.acc[eag_pkg::ACC_FAULT_BIT])))
        else $error("Fault event in wrong direction");

    AST_REA_DIR: assert property (@(posedge pclk) disable iff (!presetn) // R03
        evt[eag_pkg::IRQ_REA_BIT] |->
        $past(rea_smp_neg) == !$past(r.acc[eag_pkg::ACC_REA_SEL_BIT]))
        else $error("Reactive sign event in wrong direction");

    AST_ACT_DIR: assert property (@(posedge pclk) disable iff (!presetn) // R04
        evt[eag_pkg::IRQ_ACT_BIT] |->
        $past(act_smp_neg) == !$past(r.acc[eag_pkg::ACC_ACT_SEL_BIT]))
        else $error("Active sign event in wrong direction");

    AST_REA_ABS: assert property (@(posedge pclk) disable iff (!presetn) // R05
        ($past(power_valid) && $past(r.acc[eag_pkg::ACC_REA_ABS_BIT]))
        |-> !reactive_accum_value[eag_pkg::PWR_W-1])
        else $error("Absolute reactive value negative");

    AST_REA_SBA: assert property (@(posedge pclk) disable iff (!presetn) // R06
        ($past(power_valid) && $past(r.acc[3:2]) == 2'b01
         && $past(active_power[eag_pkg::PWR_W-1]) && $past(reactive_power) != PWR_MIN)
        |-> (reactive_accum_value + $past(reactive_power)) == '0)
        else $error("Reactive sign not inverted");

    AST_ACT_POS: assert property (@(posedge pclk) disable iff (!presetn) // R07
        ($past(power_valid) && $past(r.acc[1:0]) == 2'b10)
        |-> active_accum_value == (($past(active_power) >= PWR_MIN) ? '0 : $past(active_power)))
        else $error("Positive only active mismatch");

    AST_ACT_ABS: assert property (@(posedge pclk) disable iff (!presetn) // R08
        ($past(power_valid) && $past(r.acc[eag_pkg::ACC_ACT_ABS_BIT]))
        |-> !active_accum_value[eag_pkg::PWR_W-1])
        else $error("Absolute active value negative");

    AST_GAIN_WR: assert property (@(posedge pclk) disable iff (!presetn) // R09 R10 R11
        (access_ph && pwrite && paddr == eag_pkg::ADDR_GAIN)
        |=> voltage_amp_gain == $past(pwdata[7:5]) && current_amp_gain == $past(pwdata[2:0])
        && pulse_sign_detect_location == $past(pwdata[3]))
        else $error("Gain fields not updated");

    AST_ACT_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // R12
        evt[eag_pkg::IRQ_ACT_BIT] |=> r.status[eag_pkg::IRQ_ACT_BIT])
        else $error("Active sign flag not set");

    AST_FAULT_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // R13
        evt[eag_pkg::IRQ_FAULT_BIT] |=> r.status[eag_pkg::IRQ_FAULT_BIT])
        else $error("Fault flag not set");

endmodule // eag_top

/* File: hdl/eag_pkg.sv */
// Constants shared by the energy accumulation and gain configuration block
package eag_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int PWR_W      = 24;   // Power sample width, two's complement
    localparam int GAIN_FLD_W = 3;    // Amplifier gain field width
    localparam int IRQ_W      = 3;    // Number of interrupt sources

    // ==========================================================
    // Register indices and APB byte addresses
    // ==========================================================
    localparam logic [9:0]  IDX_ACC   = 10'h00f;  // Accumulation mode control
    localparam logic [9:0]  IDX_GAIN  = 10'h01b;  // Channel gain control
    localparam logic [9:0]  IDX_STAT  = 10'h020;  // Interrupt status
    localparam logic [9:0]  IDX_MASK  = 10'h021;  // Interrupt mask
    localparam logic [11:0] ADDR_ACC  = {IDX_ACC, 2'h0};
    localparam logic [11:0] ADDR_GAIN = {IDX_GAIN, 2'h0};
    localparam logic [11:0] ADDR_STAT = {IDX_STAT, 2'h0};
    localparam logic [11:0] ADDR_MASK = {IDX_MASK, 2'h0};

    // ==========================================================
    // Accumulation mode control fields
    // ==========================================================
    localparam int ACC_TAMPER_BIT  = 7;  // Tamper current input indicator
    localparam int ACC_FAULT_BIT   = 6;  // Fault event select
    localparam int ACC_REA_SEL_BIT = 5;  // Reactive sign event select
    localparam int ACC_ACT_SEL_BIT = 4;  // Active sign event select
    localparam int ACC_REA_ABS_BIT = 3;  // Reactive absolute accumulate
    localparam int ACC_REA_SBA_BIT = 2;  // Reactive signed by active
    localparam int ACC_ACT_POS_BIT = 1;  // Active positive only
    localparam int ACC_ACT_ABS_BIT = 0;  // Active absolute
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] ACC_WMASK = 8'h7f;  // Indicator bit is read only

    // ==========================================================
    // Channel gain control fields
    // ==========================================================
    localparam int GAIN_VOLT_LSB = 5;  // Voltage amp gain [7:5]
    localparam int GAIN_LOC_BIT  = 3;  // Pulse sign detect location
    localparam int GAIN_CUR_LSB  = 0;  // Current amp gain [2:0]
    localparam logic [7:0] GAIN_RESET = 8'h00;
    localparam logic [7:0] GAIN_WMASK = 8'hef;  // Bit 4 reserved

    // ==========================================================
    // Interrupt status and mask fields
    // ==========================================================
    localparam int IRQ_ACT_BIT   = 0;  // Active power sign change
    localparam int IRQ_REA_BIT   = 1;  // Reactive power sign change
    localparam int IRQ_FAULT_BIT = 2;  // Fault mode change
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

endpackage

/* File: hdl/eag_sign_event.sv */
// Directional level change detector used for sign and fault events
`timescale 1ns/10ps

module eag_sign_event
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Sample side
    input  wire logic sample_valid,     // New sample this cycle
    input  wire logic sample_level,     // Negative sign or fault level
    input  wire logic rising_select,    // 1: high to low, 0: low to high
    // Event side
    output logic      change_event      // One cycle pulse
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed
    {
        logic primed;     // A first sample has been seen
        logic last_level; // Level of the previous sample
        logic event_hit;  // Registered event pulse
    } eag_sign_state_s;

    eag_sign_state_s state_reg;   // Registered state
    eag_sign_state_s state_next;  // Next state

    // Next state: event when level moves in the selected direction
    always_comb
    begin
        state_next           = state_reg;
        state_next.event_hit = 1'b0;
        if (sample_valid)
        begin
            // Select 0 wants low to high, select 1 wants high to low
            if (state_reg.primed && (state_reg.last_level != sample_level) &&
                (sample_level == ~rising_select))
            begin
                state_next.event_hit = 1'b1;
            end
            state_next.last_level = sample_level;
            state_next.primed     = 1'b1;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign change_event = state_reg.event_hit;

endmodule // eag_sign_event

/* File: verif/test_eag_top.sv */
// Register-level testbench for the accumulation mode and gain configuration block
`timescale 1ns/10ps

module test_eag_top;

    // ==========================================================
    // Signals
    // ==========================================================
    logic        pclk, presetn, psel, penable, pwrite;            // APB controls
    logic [11:0] paddr;                                            // APB byte address
    logic [31:0] pwdata, prdata, rdat;                             // APB data
    logic        pready, pslverr, rerr, irq;                       // Answers
    logic        power_valid, fault_mode, tamper;                  // Core levels
    logic        a_pls, a_neg, r_pls, r_neg;                       // Energy pulses
    logic [23:0] active_power, reactive_power;                     // Power samples
    logic        a_val, r_val, loc;                                // Feed and location
    logic [23:0] a_out, r_out;                                     // Shaped samples
    logic [2:0]  v_gain, c_gain, g;                                // Gain fields
    int          error_cnt, checks;                                // Report counters
    // Shaping table: mode, active in, reactive in, expected out
    logic [7:0]  md [10] = '{8'h00, 8'h01, 8'h02, 8'h02, 8'h03, 8'h01, 8'h08, 8'h04, 8'h04, 8'h0c};
    logic [23:0] ta [10] = '{24'hfffffb, 24'hfffffb, 24'hfffffb, 24'h000005, 24'hfffffb,
                             24'h800000, 24'hfffffb, 24'hfffffb, 24'h000005, 24'hfffffb};
    logic [23:0] tr [10] = '{24'hfffffd, 24'hfffffd, 24'h000003, 24'h000003, 24'h000003,
                             24'h000003, 24'hfffffd, 24'h000003, 24'h000003, 24'h000003};
    logic [23:0] ea [10] = '{24'hfffffb, 24'h000005, 24'h000000, 24'h000005, 24'h000005,
                             24'h7fffff, 24'hfffffb, 24'hfffffb, 24'h000005, 24'hfffffb};
    logic [23:0] er [10] = '{24'hfffffd, 24'hfffffd, 24'h000003, 24'h000003, 24'h000003,
                             24'h000003, 24'h000003, 24'hfffffd, 24'h000003, 24'h000003};

    // ==========================================================
    // Design under test
    // ==========================================================
    eag_top dut
    (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_valid(power_valid), .active_power(active_power),
        .reactive_power(reactive_power), .active_pulse(a_pls),
        .active_pulse_negative(a_neg), .reactive_pulse(r_pls),
        .reactive_pulse_negative(r_neg), .fault_mode(fault_mode),
        .tamper_current_input_indicator(tamper), .active_accum_valid(a_val),
        .active_accum_value(a_out), .reactive_accum_valid(r_val),
        .reactive_accum_value(r_out), .voltage_amp_gain(v_gain), .current_amp_gain(c_gain),
        .pulse_sign_detect_location(loc), .irq(irq)
    );

    // ==========================================================
    // Clock and watchdog
    // ==========================================================
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Cuts a hang short
    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        close_out();
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    // Compares one value and reports a mismatch
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run
    task automatic close_out;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One APB transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            error_cnt++;
            close_out();
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Register write
    task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
        apb(1'b1, addr, wd);
    endtask

    // Register read with expected value, no error expected
    task automatic rd(input string what, input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(what, rdat, exp);
        check("pslverr", {31'h0, rerr}, 32'h0);
    endtask

    // Lets n edges pass, then settles
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // One power sample, returns in the cycle where the feed answers
    task automatic feed(input logic [23:0] a, input logic [23:0] r);
        @(posedge pclk);
        power_valid    <= 1'b1;
        active_power   <= a;
        reactive_power <= r;
        @(posedge pclk) power_valid <= 1'b0;
        #1;
    endtask

    // One energy pulse on each output with its sign
    task automatic pulse(input logic an, input logic rn);
        @(posedge pclk);
        a_pls <= 1'b1;
        a_neg <= an;
        r_pls <= 1'b1;
        r_neg <= rn;
        @(posedge pclk);
        a_pls <= 1'b0;
        r_pls <= 1'b0;
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        {presetn, psel, penable, pwrite, power_valid, fault_mode, tamper} = '0;
        {a_pls, a_neg, r_pls, r_neg, paddr, pwdata, active_power, reactive_power} = '0;
        error_cnt = 0;
        checks = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and the read-only indicator bit
        rd("acc", eag_pkg::ADDR_ACC, 32'h00);
        rd("gain", eag_pkg::ADDR_GAIN, 32'h00);
        rd("status", eag_pkg::ADDR_STAT, 32'h0);
        rd("mask", eag_pkg::ADDR_MASK, 32'h0);
        @(posedge pclk);
        tamper <= 1'b1;
        wr(eag_pkg::ADDR_ACC, 32'hff);
        rd("acc", eag_pkg::ADDR_ACC, 32'hff);
        @(posedge pclk);
        tamper <= 1'b0;
        rd("acc", eag_pkg::ADDR_ACC, 32'h7f);
        // Every defined gain code on both fields, reserved bit written as one
        for (int i = 0; i < 5; i++)
        begin
            g = 3'(i);
            wr(eag_pkg::ADDR_GAIN, {24'h0, g, 1'b1, g[0], 3'(4 - i)});
            rd("gain", eag_pkg::ADDR_GAIN, {24'h0, g, 1'b0, g[0], 3'(4 - i)});
            check("v_gain", {29'h0, v_gain}, {29'h0, g});
            check("c_gain", {29'h0, c_gain}, 32'(4 - i));
            check("loc", {31'h0, loc}, {31'h0, g[0]});
        end
        // Accumulation shaping table
        for (int k = 0; k < 10; k++)
        begin
            wr(eag_pkg::ADDR_ACC, {24'h0, md[k]});
            feed(ta[k], tr[k]);
            check("valid", {30'h0, a_val, r_val}, 32'h3);
            check("a_out", {8'h0, a_out}, {8'h0, ea[k]});
            check("r_out", {8'h0, r_out}, {8'h0, er[k]});
        end
        // Sign events: active positive to negative, reactive negative to positive
        wr(eag_pkg::ADDR_ACC, 32'h20);
        feed(24'h000005, 24'hfffffd);
        wr(eag_pkg::ADDR_STAT, 32'h7);
        rd("status", eag_pkg::ADDR_STAT, 32'h0);
        feed(24'hfffffb, 24'h000003);
        idle(3);
        rd("status", eag_pkg::ADDR_STAT, 32'h3);
        check("irq", {31'h0, irq}, 32'h0);
        for (int b = 0; b < 2; b++)
        begin
            wr(eag_pkg::ADDR_MASK, 32'(1 << b));
            idle(1);
            check("irq", {31'h0, irq}, 32'h1);
            wr(eag_pkg::ADDR_STAT, 32'(1 << b));
            idle(1);
            check("irq", {31'h0, irq}, 32'h0);
        end
        // Opposite directions raise nothing
        feed(24'h000005, 24'hfffffd);
        idle(3);
        rd("status", eag_pkg::ADDR_STAT, 32'h0);
        // Fault entry, then fault exit
        wr(eag_pkg::ADDR_ACC, 32'h00);
        @(posedge pclk);
        fault_mode <= 1'b1;
        idle(4);
        rd("status", eag_pkg::ADDR_STAT, 32'h4);
        wr(eag_pkg::ADDR_STAT, 32'h4);
        wr(eag_pkg::ADDR_ACC, 32'h40);
        @(posedge pclk);
        fault_mode <= 1'b0;
        idle(4);
        rd("status", eag_pkg::ADDR_STAT, 32'h4);
        wr(eag_pkg::ADDR_STAT, 32'h4);
        // Per-pulse detection ignores the filtered samples
        wr(eag_pkg::ADDR_GAIN, 32'h08);
        wr(eag_pkg::ADDR_ACC, 32'h00);
        feed(24'h000005, 24'h000003);
        feed(24'hfffffb, 24'hfffffd);
        idle(3);
        rd("status", eag_pkg::ADDR_STAT, 32'h0);
        pulse(1'b0, 1'b0);
        pulse(1'b0, 1'b0);
        wr(eag_pkg::ADDR_STAT, 32'h7);
        pulse(1'b1, 1'b1);
        idle(3);
        rd("status", eag_pkg::ADDR_STAT, 32'h3);
        // Unmapped address is refused and changes nothing
        apb(1'b1, 12'h040, 32'hff);
        check("pslverr", {31'h0, rerr}, 32'h1);
        apb(1'b0, 12'h040, 32'h0);
        check("pslverr", {31'h0, rerr}, 32'h1);
        check("prdata", rdat, 32'h0);
        rd("acc", eag_pkg::ADDR_ACC, 32'h00);
        close_out();
    end

endmodule // test_eag_top
